// >>> rtl/quad_line_iface_regmap.v
// register bank of the four-channel line interface with bank pointer
// Summary of operation
// - primary addresses 16h to 1Eh are reserved, read zero, ignore writes
// - bank pointer at 1Fh is read/write and present in both banks
// - index at 10h selects template entry reached through 11h
// - signal-absent status at 04h is read-only
// - driver-fault status at 05h is read-only
// - signal-absent mask at 06h read/write, flag at 08h read-only
// - driver-fault mask at 07h read/write, flag at 09h read-only
// - alarm status 13h read-only, mask 14h read/write, flag 15h read-only
// - loopback registers at 01h, 02h and 0Ch are read/write
// - all-ones transmit 03h and auto all-ones 0Eh are read/write
// - read/write configuration at 0Bh, 0Dh, 0Fh and 12h
// - masked status change sets flag and pulls interrupt low
// - status read clears its flags; interrupt releases when none pending
// - write to soft reset starts about 1 us reset of all registers except the template memory
`timescale 1ns/1ps
`include "quad_line_iface_map.vh"
module quad_line_iface_regmap #(
  parameter [7:0] PART_CODE = 8'h5a, // arbitrary value
  parameter SOFT_RESET_LEN = `SOFT_RESET_CYCLES,
  parameter TEMPLATE_DEPTH = 64,
  parameter TEMPLATE_ADDR_W = 6
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_write,
  input wire i_read,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire [7:0] i_signal_absent,
  input wire [7:0] i_driver_fault,
  input wire [7:0] i_all_ones_alarm,
  output wire o_irq_n,
  output wire o_irq_oe_n,
  output wire o_expanded_bank,
  output wire o_internal_reset,
  output reg [7:0] o_analog_loopback,
  output reg [7:0] o_remote_loopback,
  output reg [7:0] o_digital_loopback,
  output reg [7:0] o_all_ones_transmit,
  output reg [7:0] o_auto_all_ones,
  output reg [7:0] o_perf_monitor_cfg,
  output reg [7:0] o_alarm_criteria,
  output reg [7:0] o_global_config,
  output reg [7:0] o_output_enable,
  output reg [7:0] o_expanded_write_addr,
  output reg [7:0] o_expanded_write_data,
  output reg o_expanded_write
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESET = 2'b10;
  reg [1:0] state;
  reg [15:0] reset_count;
  reg [7:0] bank_select_pointer;
  reg [7:0] template_index;
  reg [7:0] signal_absent_irq_mask;
  reg [7:0] driver_fault_irq_mask;
  reg [7:0] all_ones_alarm_irq_mask;
  reg [7:0] next_rdata;
  wire [4:0] addr;
  wire clear_all;
  wire primary;
  wire wr_primary;
  wire rd_primary;
  wire [7:0] signal_absent_irq_flag;
  wire [7:0] driver_fault_irq_flag;
  wire [7:0] all_ones_alarm_irq_flag;
  wire [7:0] template_data;
  wire template_write;
  wire wr_analog_loopback;
  wire wr_remote_loopback;
  wire wr_digital_loopback;
  wire wr_all_ones_transmit;
  wire wr_auto_all_ones;
  wire wr_perf_monitor;
  wire wr_alarm_criteria;
  wire wr_global_config;
  wire wr_output_enable;
  wire wr_template_index;
  wire wr_signal_absent_mask;
  wire wr_driver_fault_mask;
  wire wr_all_ones_alarm_mask;
  wire wr_pointer;
  wire wr_expanded;
  wire clr_signal_absent;
  wire clr_driver_fault;
  wire clr_all_ones_alarm;
  wire any_flag;

  assign addr = i_addr[4:0];
  assign clear_all = i_sys_rst | (state == ST_RESET);
  assign o_internal_reset = (state == ST_RESET);
  // any value other than the expanded code keeps the primary bank
  assign o_expanded_bank = (bank_select_pointer == `BANK_EXPANDED_CODE);
  assign primary = ~o_expanded_bank;
  // writes and read-clears are ignored while the internal reset runs; reads still return data
  assign wr_primary = i_write & primary & (state == ST_IDLE);
  assign rd_primary = i_read & primary & (state == ST_IDLE);
  assign template_write = wr_primary & (addr == `ADDR_TEMPLATE_DATA);
  assign wr_analog_loopback =
    wr_primary & (addr == `ADDR_ANALOG_LOOPBACK);
  assign wr_remote_loopback =
    wr_primary & (addr == `ADDR_REMOTE_LOOPBACK);
  assign wr_digital_loopback =
    wr_primary & (addr == `ADDR_DIGITAL_LOOPBACK);
  assign wr_all_ones_transmit =
    wr_primary & (addr == `ADDR_ALL_ONES_TRANSMIT);
  assign wr_auto_all_ones =
    wr_primary & (addr == `ADDR_AUTO_ALL_ONES);
  assign wr_perf_monitor =
    wr_primary & (addr == `ADDR_PERF_MONITOR);
  assign wr_alarm_criteria =
    wr_primary & (addr == `ADDR_ALARM_CRITERIA);
  assign wr_global_config =
    wr_primary & (addr == `ADDR_GLOBAL_CONFIG);
  assign wr_output_enable =
    wr_primary & (addr == `ADDR_OUTPUT_ENABLE);
  assign wr_template_index =
    wr_primary & (addr == `ADDR_TEMPLATE_INDEX);
  assign wr_signal_absent_mask =
    wr_primary & (addr == `ADDR_SIGNAL_ABSENT_MASK);
  assign wr_driver_fault_mask =
    wr_primary & (addr == `ADDR_DRIVER_FAULT_MASK);
  assign wr_all_ones_alarm_mask =
    wr_primary & (addr == `ADDR_ALL_ONES_ALARM_MASK);
  // the pointer answers in both banks
  assign wr_pointer = i_write & (addr == `ADDR_BANK_POINTER);
  assign wr_expanded =
    i_write & o_expanded_bank & (addr != `ADDR_BANK_POINTER);
  assign clr_signal_absent = rd_primary & (addr == `ADDR_SIGNAL_ABSENT);
  assign clr_driver_fault = rd_primary & (addr == `ADDR_DRIVER_FAULT);
  assign clr_all_ones_alarm =
    rd_primary & (addr == `ADDR_ALL_ONES_ALARM);
  assign any_flag = (|signal_absent_irq_flag) |
                    (|driver_fault_irq_flag) |
                    (|all_ones_alarm_irq_flag);

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      reset_count <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_primary && addr == `ADDR_SOFT_RESET) begin
            state <= ST_RESET;
            reset_count <= SOFT_RESET_LEN[15:0] - 16'h0001;
          end
        end
        ST_RESET: begin
          if (reset_count == 16'h0000)
            state <= ST_IDLE;
          else
            reset_count <= reset_count - 16'h0001;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (clear_all) begin
      template_index <= `RESET_VALUE;
      signal_absent_irq_mask <= `RESET_VALUE;
      driver_fault_irq_mask <= `RESET_VALUE;
      all_ones_alarm_irq_mask <= `RESET_VALUE;
      o_analog_loopback <= `RESET_VALUE;
      o_remote_loopback <= `RESET_VALUE;
      o_digital_loopback <= `RESET_VALUE;
      o_all_ones_transmit <= `RESET_VALUE;
      o_auto_all_ones <= `RESET_VALUE;
      o_perf_monitor_cfg <= `RESET_VALUE;
      o_alarm_criteria <= `RESET_VALUE;
      o_global_config <= `RESET_VALUE;
      o_output_enable <= `RESET_VALUE;
    end else begin
      // part code, status, flags and reserved slots ignore writes
      if (wr_analog_loopback)
        o_analog_loopback <= i_wdata;
      if (wr_remote_loopback)
        o_remote_loopback <= i_wdata;
      if (wr_digital_loopback)
        o_digital_loopback <= i_wdata;
      if (wr_all_ones_transmit)
        o_all_ones_transmit <= i_wdata;
      if (wr_auto_all_ones)
        o_auto_all_ones <= i_wdata;
      if (wr_perf_monitor)
        o_perf_monitor_cfg <= i_wdata;
      if (wr_alarm_criteria)
        o_alarm_criteria <= i_wdata;
      if (wr_global_config)
        o_global_config <= i_wdata;
      if (wr_output_enable)
        o_output_enable <= i_wdata;
      if (wr_template_index)
        template_index <= i_wdata;
      if (wr_signal_absent_mask)
        signal_absent_irq_mask <= i_wdata;
      if (wr_driver_fault_mask)
        driver_fault_irq_mask <= i_wdata;
      if (wr_all_ones_alarm_mask)
        all_ones_alarm_irq_mask <= i_wdata;
    end
  end

  // pointer is reachable from either bank
  always @(posedge i_clock) begin
    if (clear_all) begin
      bank_select_pointer <= `RESET_VALUE;
      o_expanded_write <= 1'b0;
      o_expanded_write_addr <= `RESET_VALUE;
      o_expanded_write_data <= `RESET_VALUE;
    end else begin
      o_expanded_write <= wr_expanded;
      if (wr_pointer)
        bank_select_pointer <= i_wdata;
      if (wr_expanded) begin
        // expanded contents live outside; test slots expected zero
        o_expanded_write_addr <= {3'b000, addr};
        o_expanded_write_data <= i_wdata;
      end
    end
  end

  change_flag #(.WIDTH(8)) u_signal_absent_flag (
    .i_clock(i_clock),
    .i_clear(clear_all),
    .i_status(i_signal_absent),
    .i_mask(signal_absent_irq_mask),
    .i_read_clear(clr_signal_absent),
    .o_flag(signal_absent_irq_flag)
  );

  change_flag #(.WIDTH(8)) u_driver_fault_flag (
    .i_clock(i_clock),
    .i_clear(clear_all),
    .i_status(i_driver_fault),
    .i_mask(driver_fault_irq_mask),
    .i_read_clear(clr_driver_fault),
    .o_flag(driver_fault_irq_flag)
  );

  change_flag #(.WIDTH(8)) u_all_ones_alarm_flag (
    .i_clock(i_clock),
    .i_clear(clear_all),
    .i_status(i_all_ones_alarm),
    .i_mask(all_ones_alarm_irq_mask),
    .i_read_clear(clr_all_ones_alarm),
    .o_flag(all_ones_alarm_irq_flag)
  );

  // template memory is not cleared by resets; only the index is
  template_store #(
    .DEPTH(TEMPLATE_DEPTH),
    .ADDR_W(TEMPLATE_ADDR_W)
  ) u_template (
    .i_clock(i_clock),
    .i_write(template_write),
    .i_addr(template_index[TEMPLATE_ADDR_W-1:0]),
    .i_data(i_wdata),
    .o_data(template_data)
  );

  // open-drain: the pin is pulled low while any flag is pending
  assign o_irq_n = 1'b0;
  assign o_irq_oe_n = ~any_flag;

  always @* begin
    next_rdata = 8'h00;
    if (addr == `ADDR_BANK_POINTER)
      next_rdata = bank_select_pointer;
    else if (primary) begin
      case (addr)
        `ADDR_PART_CODE: next_rdata = PART_CODE;
        `ADDR_ANALOG_LOOPBACK: next_rdata = o_analog_loopback;
        `ADDR_REMOTE_LOOPBACK: next_rdata = o_remote_loopback;
        `ADDR_ALL_ONES_TRANSMIT: next_rdata = o_all_ones_transmit;
        `ADDR_SIGNAL_ABSENT: next_rdata = i_signal_absent;
        `ADDR_DRIVER_FAULT: next_rdata = i_driver_fault;
        `ADDR_SIGNAL_ABSENT_MASK: next_rdata = signal_absent_irq_mask;
        `ADDR_DRIVER_FAULT_MASK: next_rdata = driver_fault_irq_mask;
        `ADDR_SIGNAL_ABSENT_FLAG: next_rdata = signal_absent_irq_flag;
        `ADDR_DRIVER_FAULT_FLAG: next_rdata = driver_fault_irq_flag;
        `ADDR_SOFT_RESET: next_rdata = 8'h00;
        `ADDR_PERF_MONITOR: next_rdata = o_perf_monitor_cfg;
        `ADDR_DIGITAL_LOOPBACK: next_rdata = o_digital_loopback;
        `ADDR_ALARM_CRITERIA: next_rdata = o_alarm_criteria;
        `ADDR_AUTO_ALL_ONES: next_rdata = o_auto_all_ones;
        `ADDR_GLOBAL_CONFIG: next_rdata = o_global_config;
        `ADDR_TEMPLATE_INDEX: next_rdata = template_index;
        `ADDR_TEMPLATE_DATA: next_rdata = template_data;
        `ADDR_OUTPUT_ENABLE: next_rdata = o_output_enable;
        `ADDR_ALL_ONES_ALARM: next_rdata = i_all_ones_alarm;
        `ADDR_ALL_ONES_ALARM_MASK: next_rdata = all_ones_alarm_irq_mask;
        `ADDR_ALL_ONES_ALARM_FLAG: next_rdata = all_ones_alarm_irq_flag;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else if (i_read)
      o_rdata <= next_rdata;
  end
endmodule // quad_line_iface_regmap

// >>> rtl/quad_line_iface_map.vh
// register offsets, reset values and timing counts for the line interface bank
`ifndef QUAD_LINE_IFACE_MAP_VH
`define QUAD_LINE_IFACE_MAP_VH
`define ADDR_PART_CODE 5'h00
`define ADDR_ANALOG_LOOPBACK 5'h01
`define ADDR_REMOTE_LOOPBACK 5'h02
`define ADDR_ALL_ONES_TRANSMIT 5'h03
`define ADDR_SIGNAL_ABSENT 5'h04
`define ADDR_DRIVER_FAULT 5'h05
`define ADDR_SIGNAL_ABSENT_MASK 5'h06
`define ADDR_DRIVER_FAULT_MASK 5'h07
`define ADDR_SIGNAL_ABSENT_FLAG 5'h08
`define ADDR_DRIVER_FAULT_FLAG 5'h09
`define ADDR_SOFT_RESET 5'h0a
`define ADDR_PERF_MONITOR 5'h0b
`define ADDR_DIGITAL_LOOPBACK 5'h0c
`define ADDR_ALARM_CRITERIA 5'h0d
`define ADDR_AUTO_ALL_ONES 5'h0e
`define ADDR_GLOBAL_CONFIG 5'h0f
`define ADDR_TEMPLATE_INDEX 5'h10
`define ADDR_TEMPLATE_DATA 5'h11
`define ADDR_OUTPUT_ENABLE 5'h12
`define ADDR_ALL_ONES_ALARM 5'h13
`define ADDR_ALL_ONES_ALARM_MASK 5'h14
`define ADDR_ALL_ONES_ALARM_FLAG 5'h15
`define ADDR_RESERVED_FIRST 5'h16
`define ADDR_RESERVED_LAST 5'h1e
`define ADDR_TEST_FIRST 5'h10
`define ADDR_BANK_POINTER 5'h1f
`define BANK_EXPANDED_CODE 8'haa
`define RESET_VALUE 8'h00
`define SOFT_RESET_NS 1000
`define CLOCK_PERIOD_NS 5
`define SOFT_RESET_CYCLES (`SOFT_RESET_NS / `CLOCK_PERIOD_NS)
`endif

// >>> rtl/change_flag.v
// sticky per-channel change flag with mask, cleared on status read
`timescale 1ns/1ps
module change_flag #(
  parameter WIDTH = 8
) (
  input wire i_clock,
  input wire i_clear,
  input wire [WIDTH-1:0] i_status,
  input wire [WIDTH-1:0] i_mask,
  input wire i_read_clear,
  output reg [WIDTH-1:0] o_flag
);
  reg [WIDTH-1:0] last_status;
  wire [WIDTH-1:0] event_set;
  assign event_set = (i_status ^ last_status) & i_mask;
  always @(posedge i_clock) begin
    if (i_clear) begin
      last_status <= {WIDTH{1'b0}};
      o_flag <= {WIDTH{1'b0}};
    end else begin
      last_status <= i_status;
      // set beats the read clear so no change is lost
      if (i_read_clear)
        o_flag <= event_set;
      else
        o_flag <= o_flag | event_set;
    end
  end
endmodule // change_flag

// >>> rtl/template_store.v
// small template memory with registered read data
`timescale 1ns/1ps
module template_store #(
  parameter DEPTH = 64,
  parameter ADDR_W = 6
) (
  input wire i_clock,
  input wire i_write,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_data,
  output reg [7:0] o_data
);
  reg [7:0] mem [0:DEPTH-1];
  always @(posedge i_clock) begin
    if (i_write)
      mem[i_addr] <= i_data;
    o_data <= mem[i_addr];
  end
endmodule // template_store

// >>> verif/quad_line_iface_regmap_asserts.sv
// port assertions for the line interface register bank
`timescale 1ns/1ps
module regmap_checker #(
  parameter [7:0] PART_CODE = 8'h5a
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_write,
  input wire i_read,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire o_expanded_bank,
  input wire o_internal_reset,
  input wire [7:0] o_analog_loopback,
  input wire [7:0] o_expanded_write_addr,
  input wire o_expanded_write
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire [4:0] a = i_addr[4:0];
  wire prim = !o_expanded_bank && !o_internal_reset;
  property p_bank_set; i_write && a == 5'h1f && i_wdata == 8'haa
    && !o_internal_reset |=> o_expanded_bank; endproperty
  a_bank_set: assert property (p_bank_set) else $error("no bank");
  property p_bank_clr; i_write && a == 5'h1f && i_wdata == 8'h00
    |=> !o_expanded_bank; endproperty
  a_bank_clr: assert property (p_bank_clr) else $error("bank");
  property p_soft_rd; i_read && a == 5'h0a |=> o_rdata == 8'h00;
  endproperty
  a_soft_rd: assert property (p_soft_rd) else $error("wo read");
  property p_resv; i_read && a >= 5'h16 && a <= 5'h1e && !o_expanded_bank
    |=> o_rdata == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved read");
  property p_part; i_read && a == 5'h00 && !o_expanded_bank
    |=> o_rdata == PART_CODE; endproperty
  a_part: assert property (p_part) else $error("part code");
  // the bench shortens the soft reset to four cycles
  property p_soft; i_write && a == 5'h0a && prim
    |=> o_internal_reset [*4] ##1 !o_internal_reset; endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_loop; i_write && a == 5'h01 && prim
    |=> o_analog_loopback == $past(i_wdata); endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_fwd; i_write && o_expanded_bank && !o_internal_reset
    && a != 5'h1f |=> o_expanded_write
    && o_expanded_write_addr == {3'h0, $past(a)}; endproperty
  a_fwd: assert property (p_fwd) else $error("expanded write");
endmodule // regmap_checker
bind quad_line_iface_regmap regmap_checker #(.PART_CODE(PART_CODE)) chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_write(i_write),
  .i_read(i_read), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_expanded_bank(o_expanded_bank), .o_internal_reset(o_internal_reset),
  .o_analog_loopback(o_analog_loopback),
  .o_expanded_write_addr(o_expanded_write_addr),
  .o_expanded_write(o_expanded_write));

// >>> verif/host_port_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
module host_port_model (
  input wire i_clock,
  input wire [7:0] i_rdata,
  output reg o_write = 1'b0,
  output reg o_read = 1'b0,
  output reg [7:0] o_addr = 8'h00,
  output reg [7:0] o_wdata = 8'h00
);
  integer k;
  // released lines show the inverse so a stale value never looks valid
  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(posedge i_clock);
      #1 o_write = 1'b1;
      o_addr = ad;
      o_wdata = d;
      @(posedge i_clock);
      #1 o_write = 1'b0;
      o_addr = ~ad;
      o_wdata = ~d;
    end
  endtask
  task rd(input [7:0] ad, output [7:0] d);
    begin
      @(posedge i_clock);
      #1 o_read = 1'b1;
      o_addr = ad;
      @(posedge i_clock);
      #1 o_read = 1'b0;
      o_addr = ~ad;
      d = i_rdata;
    end
  endtask
  // test places of the expanded bank only ever get zero
  task clear_test_regs;
    for (k = 16; k < 31; k = k + 1) wr(k[7:0], 8'h00);
  endtask
endmodule // host_port_model

// >>> verif/test_quad_line_iface_regmap.sv
// self-checking bench for the line interface register bank
`timescale 1ns/1ps
module test_quad_line_iface_regmap;
  localparam [7:0] PC = 8'h3c; // arbitrary value
  localparam [95:0] RWA = 96'h01_02_03_06_07_0b_0c_0d_0e_0f_12_14;
  localparam [55:0] ROA = 56'h00_04_05_08_09_13_15;
  reg i_clock = 1'b0;
  reg i_sys_rst = 1'b1;
  reg [7:0] sig_abs = 8'h00, drv_flt = 8'h00, alarm = 8'h00, v;
  wire wr_s, rd_s, irq_oe_n, exp_bank, int_rst;
  wire [7:0] addr, wdata, rdata, aloop;
  wire irq_n, ew;
  wire [7:0] rloop, dloop, aot, aaot, perf_monitor_cfg, crit, global_config, outen, ewa, ewd;
  integer failures = 0, checks = 0, cyc = 0, i;
  host_port_model host (.i_clock(i_clock), .i_rdata(rdata),
    .o_write(wr_s), .o_read(rd_s), .o_addr(addr), .o_wdata(wdata));
  quad_line_iface_regmap #(.PART_CODE(PC), .SOFT_RESET_LEN(4)) DUT (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_write(wr_s),
    .i_read(rd_s), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_signal_absent(sig_abs), .i_driver_fault(drv_flt),
    .i_all_ones_alarm(alarm), .o_irq_n(irq_n), .o_irq_oe_n(irq_oe_n),
    .o_expanded_bank(exp_bank), .o_internal_reset(int_rst),
    .o_analog_loopback(aloop), .o_remote_loopback(rloop),
    .o_digital_loopback(dloop), .o_all_ones_transmit(aot),
    .o_auto_all_ones(aaot), .o_perf_monitor_cfg(perf_monitor_cfg),
    .o_alarm_criteria(crit), .o_global_config(global_config),
    .o_output_enable(outen), .o_expanded_write_addr(ewa),
    .o_expanded_write_data(ewd), .o_expanded_write(ew));
  initial forever #2.5 i_clock = ~i_clock;
  task check(input string nm, input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  task rdchk(input string nm, input [7:0] ad, input [7:0] exp);
    begin
      host.rd(ad, v);
      check(nm, v, exp);
    end
  endtask
  task t_rw;
    begin
      for (i = 0; i < 12; i++) host.wr(RWA[95-8*i -: 8], 8'hc0 + i[7:0]);
      for (i = 0; i < 12; i++) rdchk("rw", RWA[95-8*i -: 8], 8'hc0 + i);
      check("aloop", aloop, 8'hc0);
      check("rloop", rloop, 8'hc1);
      check("dloop", dloop, 8'hc6);
      check("ones tx", aot, 8'hc2);
      check("auto ones", aaot, 8'hc8);
      check("perf mon", perf_monitor_cfg, 8'hc5);
      check("criteria", crit, 8'hc7);
      check("global cfg", global_config, 8'hc9);
      check("out enable", outen, 8'hca);
      check("irq pin", irq_n, 1'b0);
      for (i = 0; i < 7; i++) host.wr(ROA[55-8*i -: 8], 8'hff);
      for (i = 0; i < 7; i++) rdchk("ro", ROA[55-8*i -: 8], i ? 0 : PC);
      $display("done rw");
    end
  endtask
  task t_resv;
    begin
      for (i = 8'h16; i < 8'h1f; i++) host.wr(i[7:0], 8'hff);
      for (i = 8'h16; i < 8'h1f; i++) rdchk("resv", i[7:0], 8'h00);
      rdchk("soft rd", 8'h0a, 8'h00);
      rdchk("upper bits", 8'he1, 8'hc0);
      $display("done reserved");
    end
  endtask
  task t_irq;
    begin
      host.wr(8'h06, 8'h0f);
      host.wr(8'h07, 8'h00);
      host.wr(8'h14, 8'hff);
      @(posedge i_clock);
      #1 sig_abs = 8'h05;
      drv_flt = 8'h01;
      alarm = 8'h80;
      repeat (2) @(posedge i_clock);
      #1 check("irq", irq_oe_n, 1'b0);
      rdchk("sa flag", 8'h08, 8'h05);
      rdchk("fault flag", 8'h09, 8'h00);
      rdchk("al flag", 8'h15, 8'h80);
      rdchk("sa stat", 8'h04, 8'h05);
      rdchk("fault stat", 8'h05, 8'h01);
      rdchk("al stat", 8'h13, 8'h80);
      rdchk("sa clr", 8'h08, 8'h00);
      rdchk("al clr", 8'h15, 8'h00);
      check("irq off", irq_oe_n, 1'b1);
      // a falling status bit counts as a change as well
      sig_abs = 8'h00;
      rdchk("sa fall", 8'h08, 8'h05);
      check("irq fall", irq_oe_n, 1'b0);
      // new change lands on the clearing read: the set must win
      fork
        rdchk("sa race", 8'h04, 8'h01);
        begin
          @(posedge i_clock);
          #1 sig_abs = 8'h01;
        end
      join
      rdchk("sa set wins", 8'h08, 8'h01);
      rdchk("sa stat2", 8'h04, 8'h01);
      check("irq off2", irq_oe_n, 1'b1);
      $display("done irq");
    end
  endtask
  task t_tmpl;
    begin
      host.wr(8'h10, 8'h05);
      host.wr(8'h11, 8'ha5);
      host.wr(8'h10, 8'h06);
      host.wr(8'h11, 8'h3c);
      host.wr(8'h10, 8'h05);
      repeat (2) @(posedge i_clock);
      rdchk("tmpl", 8'h11, 8'ha5);
      rdchk("index", 8'h10, 8'h05);
      $display("done template");
    end
  endtask
  task t_bank;
    begin
      host.wr(8'h1f, 8'haa);
      check("exp", exp_bank, 1'b1);
      rdchk("ptr", 8'h1f, 8'haa);
      rdchk("exp rd", 8'h01, 8'h00);
      host.wr(8'h03, 8'h5c);
      check("exp strobe", ew, 1'b1);
      check("exp addr", ewa, 8'h03);
      check("exp data", ewd, 8'h5c);
      host.clear_test_regs;
      check("test addr", ewa, 8'h1e);
      check("test data", ewd, 8'h00);
      host.wr(8'h1f, 8'h00);
      check("prim", exp_bank, 1'b0);
      rdchk("back", 8'h01, 8'hc0);
      $display("done bank");
    end
  endtask
  task t_soft;
    begin
      host.wr(8'h0a, 8'h00);
      check("rst on", int_rst, 1'b1);
      // a write inside the reset window must be dropped
      host.wr(8'h01, 8'h55);
      repeat (5) @(posedge i_clock);
      #1 check("rst off", int_rst, 1'b0);
      check("aloop", aloop, 8'h00);
      rdchk("mask", 8'h06, 8'h00);
      $display("done soft reset");
    end
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_sys_rst = 1'b0;
    t_rw;
    t_resv;
    t_irq;
    t_tmpl;
    t_bank;
    t_soft;
    print_verdict;
  end
endmodule // test_quad_line_iface_regmap
